// File: acs_top.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps

// Functional notes
// - Sampling takes four converter clocks, then conversion takes twelve.
// - Conversion runs in hardware; the bus stays free meanwhile.
// - Converter clock is system clock divided by two to the power of a 3-bit field.
// - Internal source selected disconnects every external channel.
// - External source routes the selected channel when it is below EXT_CHANNELS; software sets that pin analog.
// - Format bit sets alignment of the result across high and low bytes.
// - Reference select field chooses converter reference, amplifier output included.
// - A low-high-low pulse on the start bit begins a conversion.
// - Busy reads one while converting, zero at completion with result valid.
// - Completion sets the converter interrupt flag.
// - Interrupt reaches the processor only with global and converter enables set.
// - Result is a 12-bit unsigned code, full reference giving all ones.
// - One code step is the reference divided by 4096.
// - Code transitions sit half a step low, full scale one and a half low.
module acs_top
  import acs_pkg::*;
#(
  parameter logic [CH_W-1:0] EXT_CHANNELS = EXT_CH_NUM
)(
  input  wire logic                  MCLK_IN,
  input  wire logic                  RST_B_IN,
  input  wire logic [AXI_ADDR_W-1:0] AWADDR_IN,
  input  wire logic                  AWVALID_IN,
  output logic                       AWREADY_OUT,
  input  wire logic [AXI_DATA_W-1:0] WDATA_IN,
  input  wire logic [AXI_STRB_W-1:0] WSTRB_IN,
  input  wire logic                  WVALID_IN,
  output logic                       WREADY_OUT,
  output logic [1:0]                 BRESP_OUT,
  output logic                       BVALID_OUT,
  input  wire logic                  BREADY_IN,
  input  wire logic [AXI_ADDR_W-1:0] ARADDR_IN,
  input  wire logic                  ARVALID_IN,
  output logic                       ARREADY_OUT,
  output logic [AXI_DATA_W-1:0]      RDATA_OUT,
  output logic [1:0]                 RRESP_OUT,
  output logic                       RVALID_OUT,
  input  wire logic                  RREADY_IN,
  input  wire logic                  COMP_IN,
  output logic                       CONV_POWER_OUT,
  output logic                       CONV_RESET_OUT,
  output logic                       SAMPLE_OUT,
  output logic                       CONV_TICK_OUT,
  output logic [RES_W-1:0]           TRIAL_CODE_OUT,
  output logic                       EXT_CONNECT_OUT,
  output logic [CH_W-1:0]            EXT_CHANNEL_OUT,
  output logic [SRC_W-1:0]           INPUT_SOURCE_OUT,
  output logic [REF_W-1:0]           REF_SELECT_OUT,
  output logic                       IRQ_OUT
);

  function automatic logic [AXI_DATA_W-1:0] wmerge(input logic [AXI_DATA_W-1:0] old_w,
                                                   input logic [AXI_DATA_W-1:0] new_w,
                                                   input logic [AXI_STRB_W-1:0] strb);
    logic [AXI_DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < AXI_STRB_W; i++)
    begin
      if (strb[i])
        res[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
    end
    return res;
  endfunction : wmerge

  function automatic logic [DIV_CNT_W-1:0] div_last(input logic [DIV_W-1:0] sel);
    logic [DIV_CNT_W:0] full;
    full = ({{DIV_CNT_W{1'b0}}, 1'b1} << sel) - {{DIV_CNT_W{1'b0}}, 1'b1};
    return full[DIV_CNT_W-1:0];
  endfunction : div_last

  ////////////////////////////////////////////////////////////////////////////
  // State
  acs_state_t             state_q, state_d;
  logic                   power_q, start_q, fmt_q, busy_q;
  logic [SRC_W-1:0]       src_q;
  logic [CH_W-1:0]        ch_q;
  logic [DIV_W-1:0]       div_sel_q, sel_run_q;
  logic [REF_W-1:0]       ref_q;
  logic                   flag_q, int_en_q, glob_q, irq_q;
  logic [DIV_CNT_W-1:0]   div_cnt_q;
  logic [BIT_IDX_W-1:0]   phase_q, bit_idx_q;
  logic [RES_W-1:0]       trial_q, result_q;
  logic                   conv_rst_q, sample_q, tick_q, ext_conn_q;
  logic [CH_W-1:0]        ext_ch_q;
  logic                   aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [AXI_ADDR_W-1:0]  aw_addr_q;
  logic [AXI_DATA_W-1:0]  w_data_q, rdata_q;
  logic [AXI_STRB_W-1:0]  w_strb_q;
  logic [1:0]             bresp_q, rresp_q;
  logic [AXI_DATA_W-1:0]  ctrl0_word, ctrl1_word;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes
  wire aw_hs      = AWVALID_IN & awready_q;
  wire w_hs       = WVALID_IN & wready_q;
  wire ar_hs      = ARVALID_IN & arready_q;
  wire wr_do      = aw_full_q & w_full_q & ~bvalid_q;
  wire bvalid_d   = wr_do | (bvalid_q & ~BREADY_IN);
  wire aw_full_d  = (aw_full_q | aw_hs) & ~wr_do;
  wire w_full_d   = (w_full_q | w_hs) & ~wr_do;
  wire rvalid_d   = ar_hs | (rvalid_q & ~RREADY_IN);

  wire wr_ctrl0   = wr_do & (aw_addr_q == REG_CTRL0);
  wire wr_ctrl1   = wr_do & (aw_addr_q == REG_CTRL1);
  wire wr_clear   = wr_do & (aw_addr_q == REG_INT_CLEAR);
  wire wr_int_en  = wr_do & (aw_addr_q == REG_INT_ENABLE);
  wire wr_glob    = wr_do & (aw_addr_q == REG_GLOBAL_INT);
  wire wr_ro      = wr_do & ((aw_addr_q == REG_RESULT_HI) | (aw_addr_q == REG_RESULT_LO) |
                             (aw_addr_q == REG_INT_STATUS));
  wire wr_hit     = wr_ctrl0 | wr_ctrl1 | wr_clear | wr_int_en | wr_glob | wr_ro;

  wire [AXI_DATA_W-1:0] ctrl0_mrg = wmerge(ctrl0_word, w_data_q, w_strb_q);
  wire [AXI_DATA_W-1:0] ctrl1_mrg = wmerge(ctrl1_word, w_data_q, w_strb_q);
  wire [AXI_DATA_W-1:0] clr_mrg   = wmerge(WORD_ZERO, w_data_q, w_strb_q);
  wire [AXI_DATA_W-1:0] en_mrg    = wmerge({{(AXI_DATA_W-1){1'b0}}, int_en_q}, w_data_q, w_strb_q);
  wire [AXI_DATA_W-1:0] glob_mrg  = wmerge({{(AXI_DATA_W-1){1'b0}}, glob_q}, w_data_q, w_strb_q);

  // Result alignment: format 0 is left aligned, format 1 right aligned
  wire [BYTE_W-1:0] res_hi = fmt_q ? {{(2*BYTE_W-RES_W){1'b0}}, result_q[RES_W-1:BYTE_W]}
                                   : result_q[RES_W-1:RES_W-BYTE_W];
  wire [BYTE_W-1:0] res_lo = fmt_q ? result_q[BYTE_W-1:0]
                                   : {result_q[RES_W-BYTE_W-1:0], {(2*BYTE_W-RES_W){1'b0}}};

  always_comb
  begin
    ctrl0_word                          = WORD_ZERO;
    ctrl0_word[C0_POWER]                = power_q;
    ctrl0_word[C0_START]                = start_q;
    ctrl0_word[C0_FORMAT]               = fmt_q;
    ctrl0_word[C0_BUSY]                 = busy_q;
    ctrl0_word[C0_SRC_LSB +: SRC_W]     = src_q;
    ctrl0_word[C0_CH_LSB +: CH_W]       = ch_q;
    ctrl1_word                          = WORD_ZERO;
    ctrl1_word[C1_DIV_LSB +: DIV_W]     = div_sel_q;
    ctrl1_word[C1_REF_LSB +: REF_W]     = ref_q;
  end

  wire rd_hit = (ARADDR_IN == REG_CTRL0) | (ARADDR_IN == REG_CTRL1) | (ARADDR_IN == REG_RESULT_HI) |
                (ARADDR_IN == REG_RESULT_LO) | (ARADDR_IN == REG_INT_STATUS) |
                (ARADDR_IN == REG_INT_CLEAR) | (ARADDR_IN == REG_INT_ENABLE) | (ARADDR_IN == REG_GLOBAL_INT);
  wire [AXI_DATA_W-1:0] rd_word =
    (ARADDR_IN == REG_CTRL0)      ? ctrl0_word :
    (ARADDR_IN == REG_CTRL1)      ? ctrl1_word :
    (ARADDR_IN == REG_RESULT_HI)  ? {{(AXI_DATA_W-BYTE_W){1'b0}}, res_hi} :
    (ARADDR_IN == REG_RESULT_LO)  ? {{(AXI_DATA_W-BYTE_W){1'b0}}, res_lo} :
    (ARADDR_IN == REG_INT_STATUS) ? {{(AXI_DATA_W-1){1'b0}}, flag_q} :
    (ARADDR_IN == REG_INT_ENABLE) ? {{(AXI_DATA_W-1){1'b0}}, int_en_q} :
    (ARADDR_IN == REG_GLOBAL_INT) ? {{(AXI_DATA_W-1){1'b0}}, glob_q} : WORD_ZERO;

  // Reads never wait on the converter, so software keeps running
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_B_IN)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= WORD_ZERO;
      aw_addr_q <= REG_CTRL0;
      w_data_q  <= WORD_ZERO;
      w_strb_q  <= {AXI_STRB_W{1'b0}};
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (aw_hs)
        aw_addr_q <= {AWADDR_IN[AXI_ADDR_W-1:2], 2'h0};
      if (w_hs)
      begin
        w_data_q <= WDATA_IN;
        w_strb_q <= WSTRB_IN;
      end
      if (wr_do)
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (ar_hs)
      begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  wire                 running   = (state_q == ST_SAMPLE) | (state_q == ST_CONVERT);
  wire                 tick      = running & (div_cnt_q == div_last(sel_run_q));
  wire                 abort     = start_q | ~power_q;
  wire                 done      = (state_q == ST_CONVERT) & tick & (bit_idx_q == {BIT_IDX_W{1'b0}}) & ~abort;
  wire [RES_W-1:0]     cur_bit   = {{(RES_W-1){1'b0}}, 1'b1} << bit_idx_q;
  wire [RES_W-1:0]     next_bit  = cur_bit >> 1;
  // Keep the trial bit only when the comparator says input is above the trial level.
  // Comparator answers the registered trial code within one cycle, so it is read directly:
  // a two-stage synchroniser would hand back a stale decision at divide by one and two
  wire [RES_W-1:0]     trial_nx  = (COMP_IN ? trial_q : (trial_q & ~cur_bit)) | next_bit;
  wire                 src_ext   = (src_q == SRC_EXT_A) | (src_q == SRC_EXT_B);
  wire                 flag_d    = done | (flag_q & ~(wr_clear & clr_mrg[INT_DONE]));

  always_comb
  begin
    state_d = state_q;
    if (!power_q)
      state_d = ST_IDLE;
    else if (start_q)
      state_d = ST_HOLD;
    else
    begin
      case (state_q)
        ST_IDLE:    state_d = ST_IDLE;
        ST_HOLD:    state_d = ST_SAMPLE;
        ST_SAMPLE:  state_d = (tick && phase_q == SAMPLE_TICKS - 4'h1) ? ST_CONVERT : ST_SAMPLE;
        ST_CONVERT: state_d = done ? ST_IDLE : ST_CONVERT;
        default:    state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_B_IN)
    begin
      state_q   <= ST_IDLE;
      power_q   <= 1'b0;
      start_q   <= 1'b0;
      fmt_q     <= 1'b0;
      src_q     <= SRC_EXT_A;
      ch_q      <= {CH_W{1'b0}};
      div_sel_q <= {DIV_W{1'b0}};
      ref_q     <= {REF_W{1'b0}};
      int_en_q  <= 1'b0;
      glob_q    <= 1'b0;
      flag_q    <= 1'b0;
      irq_q     <= 1'b0;
      busy_q    <= 1'b0;
      sel_run_q <= {DIV_W{1'b0}};
      div_cnt_q <= {DIV_CNT_W{1'b0}};
      phase_q   <= {BIT_IDX_W{1'b0}};
      bit_idx_q <= {BIT_IDX_W{1'b0}};
      trial_q   <= {RES_W{1'b0}};
      result_q  <= {RES_W{1'b0}};
      conv_rst_q <= 1'b0;
      sample_q  <= 1'b0;
      tick_q    <= 1'b0;
      ext_conn_q <= 1'b0;
      ext_ch_q  <= {CH_W{1'b0}};
    end
    else
    begin
      state_q   <= state_d;
      if (wr_ctrl0)
      begin
        power_q <= ctrl0_mrg[C0_POWER];
        start_q <= ctrl0_mrg[C0_START];
        fmt_q   <= ctrl0_mrg[C0_FORMAT];
        src_q   <= ctrl0_mrg[C0_SRC_LSB +: SRC_W];
        ch_q    <= ctrl0_mrg[C0_CH_LSB +: CH_W];
      end
      if (wr_ctrl1)
      begin
        div_sel_q <= ctrl1_mrg[C1_DIV_LSB +: DIV_W];
        ref_q     <= ctrl1_mrg[C1_REF_LSB +: REF_W];
      end
      if (wr_int_en)
        int_en_q <= en_mrg[INT_DONE];
      if (wr_glob)
        glob_q <= glob_mrg[INT_DONE];
      flag_q <= flag_d;
      irq_q  <= flag_q & int_en_q & glob_q;
      busy_q <= (state_d == ST_SAMPLE) | (state_d == ST_CONVERT);
      // Divider is latched per conversion so a mid-run change cannot shorten a period
      if (state_q == ST_HOLD)
      begin
        sel_run_q <= div_sel_q;
        phase_q   <= {BIT_IDX_W{1'b0}};
        bit_idx_q <= CONV_LAST;
        trial_q   <= TRIAL_START;
      end
      div_cnt_q <= (running && !tick) ? div_cnt_q + {{(DIV_CNT_W-1){1'b0}}, 1'b1} : {DIV_CNT_W{1'b0}};
      if (state_q == ST_SAMPLE && tick)
        phase_q <= phase_q + 4'h1;
      if (state_q == ST_CONVERT && tick)
      begin
        trial_q   <= trial_nx;
        bit_idx_q <= bit_idx_q - 4'h1;
      end
      if (done)
        result_q <= trial_nx;
      conv_rst_q <= (state_d == ST_HOLD);
      sample_q   <= (state_d == ST_SAMPLE);
      tick_q     <= tick;
      ext_conn_q <= src_ext & (ch_q < EXT_CHANNELS);
      ext_ch_q   <= ch_q;
    end
  end

  // Analog side sees plain code steps; the half-step offsets live in its comparator
  assign TRIAL_CODE_OUT   = trial_q;
  assign CONV_POWER_OUT   = power_q;
  assign CONV_RESET_OUT   = conv_rst_q;
  assign SAMPLE_OUT       = sample_q;
  assign CONV_TICK_OUT    = tick_q;
  assign EXT_CONNECT_OUT  = ext_conn_q;
  assign EXT_CHANNEL_OUT  = ext_ch_q;
  assign INPUT_SOURCE_OUT = src_q;
  assign REF_SELECT_OUT   = ref_q;
  assign IRQ_OUT          = irq_q;
  assign AWREADY_OUT      = awready_q;
  assign WREADY_OUT       = wready_q;
  assign BVALID_OUT       = bvalid_q;
  assign BRESP_OUT        = bresp_q;
  assign ARREADY_OUT      = arready_q;
  assign RVALID_OUT       = rvalid_q;
  assign RDATA_OUT        = rdata_q;
  assign RRESP_OUT        = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [BIT_IDX_W-1:0] samp_h_q, conv_h_q;
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_B_IN)
    begin
      samp_h_q <= {BIT_IDX_W{1'b0}};
      conv_h_q <= {BIT_IDX_W{1'b0}};
    end
    else
    begin
      samp_h_q <= (state_q == ST_SAMPLE) ? samp_h_q + {{(BIT_IDX_W-1){1'b0}}, tick} : {BIT_IDX_W{1'b0}};
      conv_h_q <= (state_q == ST_CONVERT) ? conv_h_q + {{(BIT_IDX_W-1){1'b0}}, tick} : {BIT_IDX_W{1'b0}};
    end
  end

  a_sample_len: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    (state_q == ST_CONVERT && $past(state_q) == ST_SAMPLE) |-> samp_h_q == SAMPLE_TICKS)
    else $error("sampling phase length wrong");
  a_convert_len: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    done |-> conv_h_q == CONV_LAST)
    else $error("conversion phase length wrong");
  a_div_four: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN || abort)
    (tick && state_q == ST_SAMPLE && sel_run_q == 3'h2) |=> (!tick)[*3] ##1 tick)
    else $error("divide by four spacing wrong");
  a_start_fall: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    (state_q == ST_HOLD && !start_q && power_q) |=> busy_q && !CONV_RESET_OUT)
    else $error("start fall did not begin conversion");
  a_hold_reset: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    (start_q && power_q) |=> (CONV_RESET_OUT && !busy_q))
    else $error("converter not held while start high");
  a_done_flags: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    done |=> (!busy_q && flag_q && result_q == $past(trial_nx)))
    else $error("completion did not clear busy or set flag");
  a_flag_set_wins: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    (done && wr_clear) |=> flag_q)
    else $error("clear beat a new completion");
  a_irq_gate: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    IRQ_OUT |-> $past(flag_q && int_en_q && glob_q))
    else $error("interrupt raised without both enables");
  a_ext_cut: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    (!src_ext && $stable(src_q)) |=> !EXT_CONNECT_OUT)
    else $error("external channel left connected");
  a_unpowered: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    !power_q |=> !busy_q)
    else $error("busy without converter power");
  a_read_free: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
    (ar_hs && busy_q) |=> RVALID_OUT)
    else $error("read stalled during conversion");

endmodule : acs_top

// File: acs_pkg.sv
package acs_pkg;

  // Bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = AXI_DATA_W / 8;
  localparam int BYTE_W     = 8;

  // Register byte offsets
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL0      = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL1      = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_RESULT_HI  = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_RESULT_LO  = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] REG_INT_STATUS = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] REG_INT_CLEAR  = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] REG_INT_ENABLE = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] REG_GLOBAL_INT = 8'h1c;

  // Field positions and widths
  localparam int C0_POWER   = 0;
  localparam int C0_START   = 1;
  localparam int C0_FORMAT  = 2;
  localparam int C0_BUSY    = 3;
  localparam int C0_SRC_LSB = 4;
  localparam int C0_CH_LSB  = 8;
  localparam int C1_DIV_LSB = 0;
  localparam int C1_REF_LSB = 4;
  localparam int INT_DONE   = 0;
  localparam int SRC_W      = 4;
  localparam int CH_W       = 4;
  localparam int DIV_W      = 3;
  localparam int REF_W      = 2;
  localparam int RES_W      = 12;
  localparam int DIV_CNT_W  = 7;
  localparam int BIT_IDX_W  = 4;

  // Reset values and codes
  localparam logic [AXI_DATA_W-1:0] WORD_ZERO   = 32'h0;
  localparam logic [SRC_W-1:0]      SRC_EXT_A   = 4'h0;
  localparam logic [SRC_W-1:0]      SRC_EXT_B   = 4'h4;
  localparam logic [CH_W-1:0]       EXT_CH_NUM  = 4'hc;
  localparam logic [RES_W-1:0]      TRIAL_START = 12'h800;
  localparam logic [1:0]            RESP_OKAY   = 2'h0;
  localparam logic [1:0]            RESP_SLVERR = 2'h2;

  // Sequence lengths in converter clock periods
  localparam logic [BIT_IDX_W-1:0] SAMPLE_TICKS = 4'h4;
  localparam logic [BIT_IDX_W-1:0] CONV_BITS    = 4'hc;
  localparam logic [BIT_IDX_W-1:0] CONV_LAST    = CONV_BITS - 4'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_SAMPLE, ST_CONVERT} acs_state_t;

endpackage : acs_pkg

// File: acs_afe_model.sv
`timescale 1ns/100ps
module acs_afe_model
  import acs_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             power_in,
  input  wire logic [RES_W-1:0] trial_in,
  input  wire logic [RES_W-1:0] level_in,
  output logic                  comp_out
);
  logic toggle_q = 1'b0;
  // Unpowered comparator gives no usable answer, so it wanders
  always_ff @(posedge clk_in)
  begin
    toggle_q <= ~toggle_q;
  end
  // Decision sits half a step below each code, so a whole-code level trips at the trial itself
  assign comp_out = power_in ? (level_in >= trial_in) : toggle_q;
endmodule : acs_afe_model

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import acs_pkg::*;
  logic             clk, rst_b, awvalid, wvalid, bready, arvalid, rready, run;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rd;
  logic [3:0]       wstrb;
  logic [1:0]       resp;
  logic [11:0]      level;
  logic [15:0]      exp_b;
  wire logic        comp, awready, wready, bvalid, arready, rvalid, pwr, crst, smp, tick, econ, irq;
  wire logic [1:0]  bresp, rresp, rsel;
  wire logic [31:0] rdata;
  wire logic [11:0] trial;
  wire logic [3:0]  ech, isrc;
  int               n_fail, total_checks, s_cnt, run_cnt, t_cnt;

  acs_top dut (.MCLK_IN(clk), .RST_B_IN(rst_b), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .COMP_IN(comp),
    .CONV_POWER_OUT(pwr), .CONV_RESET_OUT(crst), .SAMPLE_OUT(smp), .CONV_TICK_OUT(tick), .TRIAL_CODE_OUT(trial),
    .EXT_CONNECT_OUT(econ), .EXT_CHANNEL_OUT(ech), .INPUT_SOURCE_OUT(isrc), .REF_SELECT_OUT(rsel), .IRQ_OUT(irq));
  acs_afe_model afe (.clk_in(clk), .power_in(pwr), .trial_in(trial), .level_in(level), .comp_out(comp));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Run length is measured from the first sampling cycle to the interrupt
  always @(posedge clk)
  begin
    if (smp)
      s_cnt <= s_cnt + 1;
    if (smp)
      run <= 1'b1;
    if (run && !irq)
      run_cnt <= run_cnt + 1;
    if (run && !irq && tick)
      t_cnt <= t_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic tmo(input bit hit);
    if (hit)
    begin
      n_fail++;
      $display("wrong value at %0t: no answer", $time);
      stop_test();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   k;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100 && !(aw_ok && w_ok); k++)
    begin
      @(posedge clk);
      aw_ok = aw_ok | awready;
      w_ok = w_ok | wready;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    tmo(!(aw_ok && w_ok));
    for (k = 0; k < 100 && bvalid !== 1'b1; k++)
      @(posedge clk);
    tmo(k >= 100);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (arready !== 1'b1 && k < 100);
    tmo(arready !== 1'b1);
    arvalid <= 1'b0;
    for (k = 0; k < 100 && rvalid !== 1'b1; k++)
      @(posedge clk);
    tmo(k >= 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rdr

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  function automatic logic [15:0] exp_bytes(input logic f, input logic [11:0] v);
    return f ? {4'h0, v} : {v, 4'h0};
  endfunction : exp_bytes

  ////////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic conv(input logic [2:0] sel, input logic f, input logic [3:0] src, input logic [3:0] ch,
                      input logic [1:0] rf, input logic [11:0] v, input logic en);
    logic [31:0] c0;
    int          k, d;
    d = 1 << sel;
    c0 = {20'h0, ch, src, 1'b0, f, 1'b0, 1'b1};
    level = v;
    exp_b = exp_bytes(f, v);
    wr(REG_CTRL1, {26'h0, rf, 1'b0, sel}, resp);
    wr(REG_CTRL0, c0, resp);
    wr(REG_CTRL0, c0 | 32'h2, resp);
    idle(2);
    chk(crst, 1'b1, "converter not held");
    run = 1'b0;
    s_cnt = 0;
    run_cnt = 0;
    t_cnt = 0;
    wr(REG_CTRL0, c0, resp);
    rdr(REG_CTRL0, rd, resp);
    chk(rd[C0_BUSY], 1'b1, "busy low while running");
    for (k = 0; k < 3000 && rd[C0_BUSY] !== 1'b0; k++)
      rdr(REG_CTRL0, rd, resp);
    tmo(k >= 3000);
    rdr(REG_RESULT_HI, rd, resp);
    chk(rd, {24'h0, exp_b[15:8]}, "high byte");
    rdr(REG_RESULT_LO, rd, resp);
    chk(rd, {24'h0, exp_b[7:0]}, "low byte");
    rdr(REG_INT_STATUS, rd, resp);
    chk(rd, 32'h1, "flag not set");
    chk(irq, en, "interrupt line");
    if (en)
    begin
      chk(run_cnt >= 16 * d - 2 && run_cnt <= 16 * d + 4, 1'b1, "run length");
      chk(s_cnt >= 4 * d - 1 && s_cnt <= 4 * d + 1, 1'b1, "sample length");
      chk(t_cnt >= 15 && t_cnt <= 17, 1'b1, "tick count");
      wr(REG_INT_CLEAR, 32'h1, resp);
      rdr(REG_INT_STATUS, rd, resp);
      chk(rd, 32'h0, "flag not cleared");
    end
    chk(econ, (src == 4'h0 || src == 4'h4) && ch < 4'hc, "connect");
    chk(ech, ch, "channel");
    chk(isrc, src, "source");
    chk(rsel, rf, "reference");
    chk(pwr, 1'b1, "power line on");
  endtask : conv

  ////////////////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] r;
    {rst_b, awvalid, wvalid, bready, arvalid, rready, run} = '0;
    {awaddr, araddr, wdata, level} = '0;
    wstrb = 4'hf;
    {n_fail, total_checks, s_cnt, run_cnt, t_cnt} = '0;
    void'($urandom(32'h05afd6c2));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdr(REG_CTRL0, rd, resp);
    chk(rd, WORD_ZERO, "control reset");
    rdr(REG_CTRL1, rd, resp);
    chk(rd, WORD_ZERO, "divider reset");
    rdr(8'h20, rd, resp);
    chk(rd, WORD_ZERO, "unmapped read data");
    chk(resp, RESP_SLVERR, "unmapped read response");
    wr(8'h20, 32'hffffffff, resp);
    chk(resp, RESP_SLVERR, "unmapped write");
    wr(REG_INT_ENABLE, 32'h1, resp);
    wr(REG_GLOBAL_INT, 32'h1, resp);
    for (int i = 0; i < 12; i++)
    begin
      r = $urandom;
      conv((i < 8) ? 3'(i) : r[2:0], r[3], {1'b0, r[4], 1'b0, r[5]}, r[9:6], r[11:10],
           (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : r[23:12], 1'b1);
    end
    // Masking case keeps the flag so the gate can be opened afterwards
    wr(REG_GLOBAL_INT, 32'h0, resp);
    conv(3'h7, 1'b0, 4'h0, 4'h2, 2'h1, 12'hfff, 1'b0);
    wr(REG_GLOBAL_INT, 32'h1, resp);
    idle(2);
    chk(irq, 1'b1, "global gate");
    wr(REG_INT_ENABLE, 32'h0, resp);
    idle(2);
    chk(irq, 1'b0, "source gate");
    wr(REG_RESULT_HI, 32'hffffffff, resp);
    chk(resp, RESP_OKAY, "read-only write");
    rdr(REG_RESULT_HI, rd, resp);
    chk(rd, {24'h0, exp_b[15:8]}, "read-only changed");
    wr(REG_INT_CLEAR, 32'h1, resp);
    wr(REG_CTRL0, 32'h2, resp);
    wr(REG_CTRL0, 32'h0, resp);
    idle(2);
    chk(crst, 1'b0, "unpowered hold");
    rdr(REG_CTRL0, rd, resp);
    chk(rd, WORD_ZERO, "unpowered busy");
    rdr(REG_INT_STATUS, rd, resp);
    chk(rd, WORD_ZERO, "unpowered flag");
    chk(pwr, 1'b0, "power line off");
    stop_test();
  end
endmodule : tb_top
